/* design/predriver_control.sv */
/*
  operating mode control and serial command decoder of a three-phase
  gate pre-driver.
  assumes pins arrive asynchronously; analog fault detectors deliver
  levels; pin pull defaults are modelled at the sampler reset values.
*/
`timescale 1ns/100ps

module predriver_control (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       sleep_n_in,
  input  wire logic       enable_input_one_in,
  input  wire logic       enable_input_two_in,
  input  wire logic [2:0] low_side_command_input_in,
  input  wire logic [2:0] high_side_command_input_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       sdi_in,
  input  wire logic       overtemp_in,
  input  wire logic       desat_in,
  input  wire logic       gate_supply_low_in,
  input  wire logic       overcurrent_in,
  input  wire logic       phase_error_in,
  input  wire logic [7:0] status_one_in,
  input  wire logic [7:0] status_two_in,
  input  wire logic [7:0] status_three_in,
  output logic [2:0]      low_gate_out,
  output logic [2:0]      high_gate_out,
  output logic            gates_hold_off_out,
  output logic            irq_out,
  output logic            sdo_out,
  output logic            sdo_oe_out,
  output logic [2:0]      op_mode_out,
  output logic            desat_mode_out,
  output logic            fullon_mode_out,
  output logic [4:0]      dead_interval_out
);

  // ==========================================================
  // pin sampling with pull defaults
  localparam int NPINS = 9;
  localparam logic [NPINS-1:0] PIN_DEFAULT = {6'h00, 3'h7};

  logic [NPINS-1:0] pin_level;
  logic [2:0]       ctl_level;
  logic [2:0]       ser_level;
  logic             enables_high;

  pin_sampler #(
    .WIDTH       (NPINS),
    .RESET_VALUE (PIN_DEFAULT)
  ) u_pins (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .pins_in   ({low_side_command_input_in, sleep_n_in, enable_input_one_in,
                 enable_input_two_in, high_side_command_input_in}),
    .level_out (pin_level)
  );

  pin_sampler #(
    .WIDTH       (3),
    .RESET_VALUE (3'h2)
  ) u_serial_pins (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .pins_in   ({sclk_in, cs_n_in, sdi_in}),
    .level_out (ser_level)
  );

  predriver_pkg::phase_cmd_s phase_cmd;
  assign phase_cmd    = '{low_side: pin_level[8:6], high_side: pin_level[2:0]};
  assign ctl_level    = pin_level[5:3];
  assign enables_high        = ctl_level[1] & ctl_level[0];

  // ==========================================================
  // serial engine, held in reset while asleep
  predriver_pkg::serial_pins_s  ser_pins;
  predriver_pkg::serial_word_s  rx;
  logic                         frame_err;
  logic                         frame_start;
  logic                         sh_sdo;
  logic                         sh_oe;
  logic [7:0]                   reply;

  assign ser_pins = '{sclk: ser_level[2], cs_n: ser_level[1], sdi: ser_level[0]};

  serial_shifter u_shift (
    .clk_in          (clk_in),
    .reset_in        (reset_in | ~ctl_level[2]),
    .pins_in         (ser_pins),
    .reply_in        (reply),
    .word_out        (rx),
    .frame_error_out (frame_err),
    .frame_start_out (frame_start),
    .sdo_out         (sh_sdo),
    .sdo_oe_out      (sh_oe)
  );

  // ==========================================================
  // state
  typedef struct packed {
    predriver_pkg::op_mode_e mode;
    logic [7:0] fault;
    logic [7:0] fault_snap;
    logic [7:0] changed;
    logic [7:0] mask;
    logic [7:0] pending;
    logic [1:0] status_sel;
    logic       lock;
    logic       desat_mode;
    logic       fullon;
    logic [4:0] dead;
    logic [2:0] ls_prev;
    logic [2:0] hs_prev;
    logic [2:0] ls_seen;
    logic       init_ls;
    logic [2:0] low_gate;
    logic [2:0] high_gate;
    logic       hold_off;
    logic       irq;
    logic       sdo;
    logic       sdo_oe;
  } state_s;

  state_s state;
  state_s next_state;

  logic [7:0] events;
  assign events = {1'b0, 1'b0, 1'b0, phase_error_in, overcurrent_in,
                   gate_supply_low_in, desat_in, overtemp_in};

  function automatic logic [7:0] pick_status(input logic [1:0] sel,
                                             input logic [7:0] s0);
    unique case (sel)
      2'h0: pick_status = s0;
      2'h1: pick_status = status_one_in;
      2'h2: pick_status = status_two_in;
      2'h3: pick_status = status_three_in;
    endcase
  endfunction

  assign reply = pick_status(state.status_sel, state.fault);

  logic [2:0]  cmd;
  logic [4:0]  data;
  logic [7:0]  nib;
  logic        protect_fault;
  logic [7:0]  set_now;

  always_comb begin
    cmd  = rx.word[predriver_pkg::CMD_MSB:predriver_pkg::CMD_LSB];
    data = rx.word[4:0];
    nib  = data[predriver_pkg::HALF_BIT] ? {data[3:0], 4'h0} : {4'h0, data[3:0]};
    protect_fault = (desat_in & state.desat_mode) | phase_error_in
                    | gate_supply_low_in;
    set_now = events;
    set_now[predriver_pkg::FLT_FRAMING] = frame_err;
    next_state = state;
    // fault latches and change tracking during a frame
    next_state.changed = state.changed | (set_now & ~state.fault);
    if (frame_start) begin
      next_state.changed    = '0;
      next_state.fault_snap = state.fault;
    end
    if (rx.valid) begin
      unique case (cmd)
        predriver_pkg::CMD_STATUS: begin
          next_state.status_sel = data[1:0];
        end
        predriver_pkg::CMD_MASK: begin
          next_state.status_sel = 2'h0;
          if (state.lock) begin
            set_now[predriver_pkg::FLT_WRLOCK] = 1'b1;
          end else if (data[predriver_pkg::HALF_BIT]) begin
            next_state.mask[7:4] = data[3:0];
          end else begin
            next_state.mask[3:0] = data[3:0];
          end
        end
        predriver_pkg::CMD_MODE: begin
          next_state.status_sel = 2'h0;
          if (state.lock) begin
            set_now[predriver_pkg::FLT_WRLOCK] = 1'b1;
          end else begin
            next_state.desat_mode = data[predriver_pkg::MODE_DESAT_BIT];
            next_state.fullon     = data[predriver_pkg::MODE_FULLON_BIT];
            next_state.lock       = data[predriver_pkg::MODE_LOCK_BIT];
          end
        end
        predriver_pkg::CMD_CLEAR: begin
          next_state.status_sel = 2'h0;
          // only latched bits that did not change in the frame clear
          next_state.fault = state.fault & ~(nib & ~state.changed);
        end
        predriver_pkg::CMD_DEADTIME: begin
          next_state.status_sel = 2'h0;
          if (state.lock) begin
            set_now[predriver_pkg::FLT_WRLOCK] = 1'b1;
          end else begin
            next_state.dead = data;
          end
        end
        default: begin
          next_state.status_sel = 2'h0;
        end
      endcase
    end
    // set wins over a clear in the same cycle
    next_state.fault   = next_state.fault | set_now;
    next_state.changed = next_state.changed | (set_now & ~state.fault);
    // interrupt latch: a signalled fault stays pending until its latch clears
    next_state.pending = (state.pending | (next_state.fault & next_state.mask))
                         & next_state.fault;
    next_state.irq     = |next_state.pending;
    // initialization edge tracking
    next_state.ls_prev = phase_cmd.low_side;
    next_state.hs_prev = phase_cmd.high_side;
    // mode selection
    if (!ctl_level[2]) begin
      next_state.mode = predriver_pkg::MODE_SLEEP;
    end else if (!enables_high) begin
      next_state.mode = predriver_pkg::MODE_STANDBY;
    end else begin
      unique case (state.mode)
        predriver_pkg::MODE_SLEEP, predriver_pkg::MODE_STANDBY: begin
          next_state.mode    = predriver_pkg::MODE_INIT;
          next_state.init_ls = 1'b0;
          next_state.ls_seen = '0;
        end
        predriver_pkg::MODE_INIT: begin
          if (|(state.ls_prev ^ phase_cmd.low_side)) begin
            next_state.init_ls = 1'b1;
          end
          if (state.init_ls && |(state.hs_prev ^ phase_cmd.high_side)) begin
            next_state.mode = predriver_pkg::MODE_ENABLE;
          end
        end
        predriver_pkg::MODE_ENABLE: begin
          if (protect_fault) begin
            next_state.mode = predriver_pkg::MODE_FAULT;
          end
        end
        predriver_pkg::MODE_FAULT: begin
          if (!protect_fault) begin
            next_state.mode    = predriver_pkg::MODE_INIT;
            next_state.init_ls = 1'b0;
            next_state.ls_seen = '0;
          end
        end
        default: begin
          next_state.mode = predriver_pkg::MODE_STANDBY;
        end
      endcase
    end
    // bootstrap: remember a low-side pulse per phase
    if (state.mode == predriver_pkg::MODE_ENABLE) begin
      next_state.ls_seen = state.ls_seen | (state.ls_prev & ~phase_cmd.low_side);
    end
    // gate drive
    next_state.hold_off  = 1'b0;
    next_state.low_gate  = '0;
    next_state.high_gate = '0;
    unique case (next_state.mode)
      predriver_pkg::MODE_SLEEP: begin
        next_state.hold_off = 1'b1;
      end
      predriver_pkg::MODE_STANDBY, predriver_pkg::MODE_FAULT: begin
        next_state.hold_off = 1'b0;
      end
      predriver_pkg::MODE_INIT: begin
        next_state.low_gate = phase_cmd.low_side;
      end
      predriver_pkg::MODE_ENABLE: begin
        next_state.low_gate  = phase_cmd.low_side;
        next_state.high_gate = ~phase_cmd.high_side & next_state.ls_seen;
        if (!state.fullon) begin
          next_state.high_gate = next_state.high_gate & ~phase_cmd.low_side;
        end
      end
      default: begin
        next_state.hold_off = 1'b1;
      end
    endcase
    next_state.sdo    = sh_sdo & sh_oe;
    next_state.sdo_oe = sh_oe & ctl_level[2];
    // sleep reloads the fault flags and clears changes, pending, status select and irq; mask and mode bits are kept
    if (!ctl_level[2]) begin
      next_state.fault      = predriver_pkg::FAULT_RESET;
      next_state.changed    = '0;
      next_state.pending    = '0;
      next_state.status_sel = 2'h0;
      next_state.irq        = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state            <= '0;
      state.mode       <= predriver_pkg::MODE_SLEEP;
      state.fault      <= predriver_pkg::FAULT_RESET;
      state.mask       <= predriver_pkg::MASK_RESET;
      state.dead       <= predriver_pkg::DEAD_RESET;
      state.hold_off   <= 1'b1;
      state.ls_prev    <= '0;
      state.hs_prev    <= 3'h7;
    end else begin
      state <= next_state;
    end
  end

  assign low_gate_out       = state.low_gate;
  assign high_gate_out      = state.high_gate;
  assign gates_hold_off_out = state.hold_off;
  assign irq_out            = state.irq;
  assign sdo_out            = state.sdo;
  assign sdo_oe_out         = state.sdo_oe;
  assign op_mode_out        = state.mode;
  assign desat_mode_out     = state.desat_mode;
  assign fullon_mode_out    = state.fullon;
  assign dead_interval_out  = state.dead;

endmodule

/* pkg/predriver_pkg.sv */
/*
  shared constants and carriers for the gate pre-driver mode controller
  and its 8-bit serial command interface.
  assumes one 125 MHz system clock and a synchronous active-high reset.
*/
package predriver_pkg;

  // ==========================================================
  // serial word layout
  localparam int WORD_BITS   = 8;
  localparam int CMD_MSB     = 7;
  localparam int CMD_LSB     = 5;
  localparam int NIBBLE_BITS = 4;

  // ==========================================================
  // command codes (top three bits)
  localparam logic [2:0] CMD_STATUS   = 3'h0;
  localparam logic [2:0] CMD_MASK     = 3'h1;
  localparam logic [2:0] CMD_MODE     = 3'h2;
  localparam logic [2:0] CMD_CLEAR    = 3'h3;
  localparam logic [2:0] CMD_DEADTIME = 3'h4;
  localparam int HALF_BIT             = 4;

  // ==========================================================
  // mode command fields
  localparam int MODE_LOCK_BIT   = 0;
  localparam int MODE_FULLON_BIT = 1;
  localparam int MODE_DESAT_BIT  = 3;

  // ==========================================================
  // fault flag positions: low half then high half
  localparam int FLT_OVERTEMP = 0;
  localparam int FLT_DESAT    = 1;
  localparam int FLT_UNDERV   = 2;
  localparam int FLT_OVERCUR  = 3;
  localparam int FLT_PHASE    = 4;
  localparam int FLT_FRAMING  = 5;
  localparam int FLT_WRLOCK   = 6;
  localparam int FLT_RESET    = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] MASK_RESET   = 8'hff;
  localparam logic [7:0] FAULT_RESET  = 8'h80;
  localparam logic [4:0] DEAD_RESET   = 5'h00;

  // ==========================================================
  // three-stage input sampler: second and third must agree
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    MODE_SLEEP   = 3'b000,
    MODE_STANDBY = 3'b001,
    MODE_INIT    = 3'b010,
    MODE_ENABLE  = 3'b011,
    MODE_FAULT   = 3'b100
  } op_mode_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } serial_pins_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] word;
  } serial_word_s;

  typedef struct packed {
    logic [2:0] low_side;
    logic [2:0] high_side;
  } phase_cmd_s;

endpackage

/* design/pin_sampler.sv */
/*
  samples asynchronous pins into the system clock domain.
  assumes pins are asynchronous to clk_in; a change counts when stages
  two and three agree.
*/
`timescale 1ns/100ps
module pin_sampler #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } state_s;

  state_s state;
  state_s next_state;

  // ==========================================================
  // agreement filter
  always_comb begin
    next_state    = state;
    next_state.s1 = pins_in;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (state.s2[i] == state.s3[i]) begin
        next_state.level[i] = state.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= '{s1: RESET_VALUE, s2: RESET_VALUE, s3: RESET_VALUE, level: RESET_VALUE};
    end else begin
      state <= next_state;
    end
  end

  assign level_out = state.level;

endmodule

/* design/serial_shifter.sv */
/*
  8-bit serial shift engine with framing check.
  assumes sampled sclk, active-low chip select and data; data is taken
  on sclk rising edges and driven out on falling edges, msb first.
*/
`timescale 1ns/100ps
module serial_shifter (
  input  wire logic                       clk_in,
  input  wire logic                       reset_in,
  input  wire predriver_pkg::serial_pins_s pins_in,
  input  wire logic [7:0]                 reply_in,
  output predriver_pkg::serial_word_s      word_out,
  output logic                            frame_error_out,
  output logic                            frame_start_out,
  output logic                            sdo_out,
  output logic                            sdo_oe_out
);

  typedef struct packed {
    logic       sclk_d;
    logic       cs_d;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [2:0] count;
    logic       any_bit;
    logic       sdo;
    logic       valid;
    logic       ferr;
    logic       start;
  } state_s;

  state_s state;
  state_s next_state;

  // ==========================================================
  // shifting and framing
  always_comb begin
    next_state        = state;
    next_state.sclk_d = pins_in.sclk;
    next_state.cs_d   = pins_in.cs_n;
    next_state.valid  = 1'b0;
    next_state.ferr   = 1'b0;
    next_state.start  = 1'b0;
    if (state.cs_d && !pins_in.cs_n) begin
      next_state.start     = 1'b1;
      next_state.count     = '0;
      next_state.any_bit   = 1'b0;
      next_state.shift_out = reply_in;
      next_state.sdo       = reply_in[7];
    end else if (!pins_in.cs_n) begin
      if (!state.sclk_d && pins_in.sclk) begin
        // only the last eight bits are kept for daisy chains
        next_state.shift_in  = {state.shift_in[6:0], pins_in.sdi};
        next_state.shift_out = {state.shift_out[6:0], pins_in.sdi};
        next_state.count     = state.count + 3'h1;
        next_state.any_bit   = 1'b1;
      end else if (state.sclk_d && !pins_in.sclk) begin
        next_state.sdo = state.shift_out[7];
      end
    end else if (!state.cs_d && pins_in.cs_n) begin
      if (state.any_bit && state.count == 3'h0) begin
        next_state.valid = 1'b1;
      end else begin
        next_state.ferr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= '{sclk_d: 1'b0, cs_d: 1'b1, shift_in: 8'h00, shift_out: 8'h00,
                 count: 3'h0, any_bit: 1'b0, sdo: 1'b0, valid: 1'b0,
                 ferr: 1'b0, start: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign word_out        = '{valid: state.valid, word: state.shift_in};
  assign frame_error_out = state.ferr;
  assign frame_start_out = state.start;
  assign sdo_out         = state.sdo;
  assign sdo_oe_out      = ~state.cs_d;

endmodule

/* bench/predriver_control_chk.sv */
/* port checks for predriver_control.
   assumes one clock domain; bound at the foot of this file */
`timescale 1ns/100ps
module predriver_control_chk (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       sleep_n_in,
  input wire logic       enable_input_one_in,
  input wire logic       enable_input_two_in,
  input wire logic       cs_n_in,
  input wire logic       gate_supply_low_in,
  input wire logic [2:0] low_gate_out,
  input wire logic [2:0] high_gate_out,
  input wire logic       gates_hold_off_out,
  input wire logic       irq_out,
  input wire logic       sdo_oe_out,
  input wire logic [2:0] op_mode_out
);
  // ========================================
  // assertions
  wire logic run = sleep_n_in && enable_input_one_in && enable_input_two_in;
  wire logic off = low_gate_out == 3'h0 && high_gate_out == 3'h0;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  AST_SLEEP: assert property (!sleep_n_in [*8] |-> op_mode_out == 3'h0 && !irq_out)
    else $error("not asleep");
  AST_SLEEP_OFF: assert property (op_mode_out == 3'h0 [*2] |-> gates_hold_off_out && off)
    else $error("gates not held off");
  AST_STANDBY: assert property ((sleep_n_in && !run) [*8] |-> op_mode_out == 3'h1 && off)
    else $error("not in standby");
  AST_SDO_IDLE: assert property (cs_n_in [*8] |-> !sdo_oe_out)
    else $error("data out driven");
  AST_LEAVE: assert property ((op_mode_out == 3'h3 && !run) ##1 !run [*2] |-> ##[1:6] op_mode_out != 3'h3)
    else $error("enable kept");
  AST_HIGH_WAIT: assert property ($rose(op_mode_out == 3'h3) |-> high_gate_out == 3'h0 [*3])
    else $error("high gate early");
  AST_FAULT: assert property ((op_mode_out == 3'h3 && gate_supply_low_in) [*3] |-> ##[0:6] op_mode_out == 3'h4)
    else $error("no fault mode");
  AST_REINIT: assert property ($fell(op_mode_out == 3'h4) |-> op_mode_out != 3'h3)
    else $error("enable without init");
  AST_IRQ_HOLD: assert property ((irq_out && cs_n_in && sleep_n_in) [*8] |=> irq_out)
    else $error("interrupt dropped");
  cover property (op_mode_out == 3'h3);
  cover property ($rose(op_mode_out == 3'h4));
  cover property ($fell(irq_out));
endmodule

bind predriver_control predriver_control_chk chk (.*);

/* bench/host_serial_model.sv */
/* host side model driving the serial pins.
   assumes the 125 MHz clock; serial clock period is 20 clocks */
`timescale 1ns/100ps
module host_serial_model (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdi_out
);
  // ========================================
  // idle pins and frame task
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic frame(input logic [15:0] d, input int n, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    cs_n_out = 1'b0;
    hw(10);
    for (i = n - 1; i >= 0; i--) begin
      sdi_out = d[i];
      hw(10);
      sclk_out = 1'b1;
      rx = {rx[6:0], sdo_in};
      hw(10);
      sclk_out = 1'b0;
    end
    hw(10);
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    hw(2);
  endtask
endmodule

/* bench/test_predriver_control.sv */
/* self-checking bench for predriver_control.
   assumes host_serial_model on the serial pins; inputs move 1 ns after edges */
`timescale 1ns/100ps
module test_predriver_control;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        sleep_n_in, enable_input_one_in, enable_input_two_in, sclk_in, cs_n_in;
  logic        sdi_in, overtemp_in, desat_in, gate_supply_low_in, overcurrent_in;
  logic        phase_error_in, gates_hold_off_out, irq_out, sdo_out, sdo_oe_out;
  logic        desat_mode_out, fullon_mode_out;
  logic [2:0]  low_side_command_input_in, high_side_command_input_in;
  logic [2:0]  low_gate_out, high_gate_out, op_mode_out;
  logic [7:0]  status_one_in, status_two_in, status_three_in, rx, flt;
  logic [4:0]  dead_interval_out, dv;
  logic [1:0]  sel;
  logic [31:0] seed = 32'h593f_2aad;
  int          failures = 0;
  int          n_checks = 0;
  int          k;

  always #4 clk_in = ~clk_in;
  predriver_control dut (.*);
  host_serial_model host (
    .clk_in   (clk_in),
    .sdo_in   (sdo_out),
    .sclk_out (sclk_in),
    .cs_n_out (cs_n_in),
    .sdi_out  (sdi_in)
  );

  // ========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] clr(input logic [7:0] f, input logic [7:0] c);
    if (c[7:5] == predriver_pkg::CMD_CLEAR) f &= ~(c[4] ? {c[3:0], 4'h0} : {4'h0, c[3:0]});
    return f;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 60 && op_mode_out !== m; i++) host.hw(1);
    check8({5'h0, op_mode_out}, {5'h0, m});
    if (op_mode_out !== m) report_and_stop();
  endtask
  task automatic xfer(input logic [15:0] d, input int n);
    logic [7:0] exp;
    exp = sel == 2'h0 ? flt : sel == 2'h1 ? status_one_in : sel == 2'h2 ? status_two_in
        : status_three_in;
    host.frame(d, n, rx);
    if (n == 8) check8(rx, exp);
    if (n % 8 != 0) flt |= 8'h20;
    else sel = d[7:5] == predriver_pkg::CMD_STATUS ? d[1:0] : 2'h0;
    if (n % 8 == 0) flt = clr(flt, d[7:0]);
    host.hw(12);
  endtask
  task automatic init_seq();
    low_side_command_input_in = 3'h1;
    host.hw(6);
    check8({5'h0, low_gate_out}, 8'h01);
    low_side_command_input_in = 3'h0;
    host.hw(6);
    high_side_command_input_in = 3'h6;
    host.hw(6);
    high_side_command_input_in = 3'h7;
    wait_mode(3'h3);
  endtask

  // ========================================
  // scenarios
  initial begin
    {sleep_n_in, enable_input_one_in, enable_input_two_in} = 3'h4;
    low_side_command_input_in = 3'h0;
    high_side_command_input_in = 3'h7;
    {overtemp_in, desat_in, gate_supply_low_in, overcurrent_in, phase_error_in} = 5'h00;
    seed = xs(seed);
    {status_one_in, status_two_in, status_three_in} = seed[23:0];
    flt = predriver_pkg::FAULT_RESET;
    sel = 2'h0;
    host.hw(6);
    reset_in = 1'b0;
    host.hw(10);
    check8({7'h0, irq_out}, 8'h01);
    for (k = 1; k < 5; k++) begin
      seed = xs(seed);
      {status_one_in, status_two_in, status_three_in} = seed[31:8];
      xfer({14'h0, 2'(k)}, 8);
    end
    xfer(16'h0078, 8);
    check8({7'h0, irq_out}, 8'h00);
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      xfer({8'h00, 3'h5 + 3'(seed % 3), seed[12:8]}, 8);
    end
    xfer(16'h001f, 5);
    xfer(16'h0030, 8);
    check8({7'h0, irq_out}, 8'h01);
    xfer(16'h003f, 8);
    xfer(16'h0072, 8);
    check8({7'h0, irq_out}, 8'h00);
    {overtemp_in, desat_in, overcurrent_in, phase_error_in} = 4'hf;
    host.hw(4);
    {overtemp_in, desat_in, overcurrent_in, phase_error_in} = 4'h0;
    flt |= 8'h1b;
    xfer(16'hff61, 16);
    check8({7'h0, irq_out}, 8'h01);
    xfer(16'h0000, 8);
    dv = seed[4:0];
    xfer({8'h00, predriver_pkg::CMD_DEADTIME, dv}, 8);
    check8({3'h0, dead_interval_out}, {3'h0, dv});
    xfer(16'h004b, 8);
    check8({6'h0, desat_mode_out, fullon_mode_out}, 8'h03);
    xfer({8'h00, predriver_pkg::CMD_DEADTIME, ~dv}, 8);
    flt |= 8'h40;
    check8({3'h0, dead_interval_out}, {3'h0, dv});
    {enable_input_one_in, enable_input_two_in} = 2'h3;
    wait_mode(3'h2);
    init_seq();
    high_side_command_input_in = 3'h6;
    host.hw(6);
    check8({5'h0, high_gate_out}, 8'h00);
    low_side_command_input_in = 3'h1;
    host.hw(6);
    check8({5'h0, low_gate_out}, 8'h01);
    low_side_command_input_in = 3'h0;
    host.hw(6);
    check8({5'h0, high_gate_out}, 8'h01);
    high_side_command_input_in = 3'h7;
    gate_supply_low_in = 1'b1;
    wait_mode(3'h4);
    gate_supply_low_in = 1'b0;
    wait_mode(3'h2);
    init_seq();
    enable_input_two_in = 1'b0;
    wait_mode(3'h1);
    sleep_n_in = 1'b0;
    wait_mode(3'h0);
    host.hw(4);
    check8({6'h0, gates_hold_off_out, irq_out}, 8'h02);
    sleep_n_in = 1'b1;
    host.hw(10);
    flt = predriver_pkg::FAULT_RESET;
    sel = 2'h0;
    xfer(16'h0000, 8);
    report_and_stop();
  end
endmodule
